// ---- tb/pscfg_straps.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// board strap resistors
// ------------------------------------------------------------
module pscfg_straps
	import pscfg_pkg::*;
(
	input wire logic [9:0] sel,
	output logic [9:0] pins
);
	// static levels; low is mode 0, high is mode 1
	// only the two legal mac mode combinations reach the pins
	assign pins = {sel[9:3], (sel[2:0] == 3'h5) ? 3'h5 : 3'h0};
endmodule : pscfg_straps
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb
	import pscfg_pkg::*;
;
	localparam logic [15:0] ID_H = 16'h1c2d; // arbitrary value
	localparam logic [15:0] ID_L = 16'h3e4f; // arbitrary value
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic [9:0] straps = 10'h0b8;
	logic [9:0] pins;
	pscfg_cfg_s cfg;
	int mismatches = 0;
	int n_compared = 0;

	// ------------------------------------------------------------
	// clock, partner, design
	// ------------------------------------------------------------
	initial begin
		forever #25 clk = ~clk;
	end

	pscfg_straps board (.sel(straps), .pins(pins));

	pscfg_top #(.ID_HIGH(ID_H), .ID_LOW(ID_L)) dut (
		.clk(clk), .rst(rst),
		.mac_mode_select_a(pins[0]), .mac_mode_select_b(pins[1]),
		.mac_mode_select_c(pins[2]), .autoneg_select_pin(pins[3]),
		.speed_select_pin(pins[4]), .duplex_select_pin(pins[5]),
		.isolate_select_pin(pins[6]), .address_bit0_select(pins[7]),
		.address_bit1_select(pins[8]), .address_bit2_select(pins[9]),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg(cfg)
	);

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			mismatches++;
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : rd

	task automatic ext(input logic [15:0] ptr, input logic [1:0] fn);
		wr(5'h0d, 16'h0000);
		wr(5'h0e, ptr);
		wr(5'h0d, {fn, 14'h0000});
	endtask : ext

	task automatic tend(input string name);
		$display("test %s finished", name);
	endtask : tend

	function automatic pscfg_cfg_s ecfg(input logic [9:0] s);
		pscfg_cfg_s c;
		c.mac_mode = (s[2:0] == 3'h0) ? PSCFG_MAC_MII :
			(s[2:0] == 3'h5) ? PSCFG_MAC_RMII_SLV : PSCFG_MAC_RSV;
		c.autoneg_en = s[3];
		c.speed_100 = s[4];
		c.full_duplex = ~s[5];
		c.isolate = s[6];
		c.phy_addr = s[9:7];
		c.cfg_done = 1'b1;
		return c;
	endfunction : ecfg

	task automatic boot(input logic [9:0] s);
		straps <= s;
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 20 && cfg.cfg_done !== 1'b1; i++) @(posedge clk);
		#1;
		if (cfg.cfg_done !== 1'b1) begin
			mismatches++;
			summarize();
		end
	endtask : boot

	task automatic chkcfg(input logic [9:0] s);
		chk({6'h00, cfg}, {6'h00, ecfg(s)});
		rd(5'h00, {2'b00, s[4], s[3], 1'b0, s[6], 1'b0, ~s[5], 8'h00});
		rd(5'h10, {9'h000, 1'b1, 1'b0, s[2:0] == 3'h5, s[6], s[3], ~s[5], s[4]});
		rd(5'h19, {13'h0000, s[9:7]});
	endtask : chkcfg

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		boot(10'h0b8);
		chkcfg(10'h0b8);
		tend("strap defaults");
		@(posedge clk);
		boot(10'h345);
		chkcfg(10'h345);
		@(posedge clk) straps <= 10'h0b8;
		repeat (10) @(posedge clk);
		#1 chk({6'h00, cfg}, {6'h00, ecfg(10'h345)});
		tend("inverse straps held");
		wr(5'h00, 16'h2100);
		repeat (2) @(posedge clk);
		#1 chk({6'h00, cfg}, {6'h00, ecfg(10'h315)});
		tend("software override");
		for (int i = 0; i < PSCFG_NBASE; i++)
			if (!(PSCFG_OFFS[i] inside {9'h000, 9'h002, 9'h003, 9'h00d, 9'h00e, 9'h010, 9'h019}))
				wr(PSCFG_OFFS[i][4:0], 16'h1000 + 16'(i));
		for (int i = 0; i < PSCFG_NBASE; i++)
			if (!(PSCFG_OFFS[i] inside {9'h000, 9'h002, 9'h003, 9'h00d, 9'h00e, 9'h010, 9'h019}))
				rd(PSCFG_OFFS[i][4:0], 16'h1000 + 16'(i));
		wr(5'h02, 16'hffff);
		wr(5'h03, 16'hffff);
		wr(5'h19, 16'hffff);
		rd(5'h0c, 16'h0000);
		rd(5'h1d, 16'h0000);
		rd(5'h02, ID_H);
		rd(5'h03, ID_L);
		rd(5'h19, 16'hfffe);
		tend("base map");
		ext(16'h0175, 2'h1);
		wr(5'h0e, 16'hbeef);
		rd(5'h0e, 16'hbeef);
		ext(16'h0170, 2'h2);
		wr(5'h0e, 16'h1111);
		wr(5'h0e, 16'h2222);
		ext(16'h0170, 2'h2);
		rd(5'h0e, 16'h1111);
		rd(5'h0e, 16'h2222);
		rd(5'h0e, 16'h0000);
		ext(16'h0176, 2'h3);
		wr(5'h0e, 16'haaaa);
		rd(5'h0e, 16'h0000);
		rd(5'h0e, 16'h0000);
		wr(5'h0d, 16'h0000);
		rd(5'h0e, 16'h0177);
		ext(16'h0175, 2'h2);
		rd(5'h0e, 16'hbeef);
		rd(5'h0e, 16'haaaa);
		ext(16'h0117, 2'h1);
		wr(5'h0e, 16'h5a5a);
		rd(5'h0e, 16'h5a5a);
		tend("extended map");
		summarize();
	end
endmodule : tb
`default_nettype wire

// ---- verilog/pscfg_pkg.sv ----
`default_nettype none
package pscfg_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int PSCFG_NREG = 42;
	localparam int PSCFG_NBASE = 30;
	localparam logic [8:0] PSCFG_OFF_BASIC = 9'h000;
	localparam logic [8:0] PSCFG_OFF_IDH = 9'h002;
	localparam logic [8:0] PSCFG_OFF_IDL = 9'h003;
	localparam logic [8:0] PSCFG_OFF_CTRL = 9'h00d;
	localparam logic [8:0] PSCFG_OFF_DATA = 9'h00e;
	localparam logic [8:0] PSCFG_OFF_STS = 9'h010;
	localparam logic [8:0] PSCFG_OFF_XCVR = 9'h019;
	localparam logic [8:0] PSCFG_OFFS [PSCFG_NREG] = '{
		PSCFG_OFF_BASIC, 9'h001, PSCFG_OFF_IDH, PSCFG_OFF_IDL, 9'h004, 9'h005,
		9'h006, 9'h007, 9'h008, 9'h009, 9'h00a, 9'h00b,
		PSCFG_OFF_CTRL, PSCFG_OFF_DATA, 9'h00f, PSCFG_OFF_STS, 9'h011, 9'h012,
		9'h013, 9'h014, 9'h015, 9'h016, 9'h017, 9'h018,
		PSCFG_OFF_XCVR, 9'h01a, 9'h01b, 9'h01c, 9'h01e, 9'h01f,
		9'h025, 9'h027, 9'h02a, 9'h117, 9'h131, 9'h170,
		9'h171, 9'h173, 9'h175, 9'h176, 9'h177, 9'h178};
	localparam logic [5:0] PSCFG_IDX_BASIC = 6'h00;
	localparam logic [5:0] PSCFG_IDX_IDH = 6'h02;
	localparam logic [5:0] PSCFG_IDX_IDL = 6'h03;
	localparam logic [5:0] PSCFG_IDX_CTRL = 6'h0c;
	localparam logic [5:0] PSCFG_IDX_DATA = 6'h0d;
	localparam logic [5:0] PSCFG_IDX_STS = 6'h0f;
	localparam logic [5:0] PSCFG_IDX_XCVR = 6'h18;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int PSCFG_BASIC_SPD = 13;
	localparam int PSCFG_BASIC_AN = 12;
	localparam int PSCFG_BASIC_ISO = 10;
	localparam int PSCFG_BASIC_DUP = 8;
	localparam int PSCFG_CTRL_FN_HI = 15;
	localparam int PSCFG_CTRL_FN_LO = 14;
	localparam logic [1:0] PSCFG_FN_ADDR = 2'h0;
	localparam logic [1:0] PSCFG_FN_DATA = 2'h1;
	localparam logic [1:0] PSCFG_FN_INC_RW = 2'h2;
	localparam logic [1:0] PSCFG_FN_INC_W = 2'h3;

	// ------------------------------------------------------------
	// strap vector bits and defaults
	// ------------------------------------------------------------
	localparam int PSCFG_SB_MA = 0;
	localparam int PSCFG_SB_MB = 1;
	localparam int PSCFG_SB_MC = 2;
	localparam int PSCFG_SB_AN = 3;
	localparam int PSCFG_SB_SPD = 4;
	localparam int PSCFG_SB_DUP = 5;
	localparam int PSCFG_SB_ISO = 6;
	localparam int PSCFG_SB_AD0 = 7;
	localparam int PSCFG_NSTRAP = 10;
	localparam logic [2:0] PSCFG_MODE_MII = 3'h0;
	localparam logic [2:0] PSCFG_MODE_RMII_SLV = 3'h5;
	localparam logic [2:0] PSCFG_ADDR_DEF = 3'h1;
	localparam logic [15:0] PSCFG_BASIC_DEF = 16'h3000;
	localparam logic [1:0] PSCFG_SETTLE_CYC = 2'h2;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PSCFG_MAC_MII = 2'h0,
		PSCFG_MAC_RMII_SLV = 2'h1,
		PSCFG_MAC_RSV = 2'h3
	} pscfg_mac_e;

	typedef enum logic [2:0] {
		PSCFG_ST_WAIT = 3'b001,
		PSCFG_ST_LATCH = 3'b010,
		PSCFG_ST_RUN = 3'b100
	} pscfg_st_e;

	typedef struct packed {
		pscfg_mac_e mac_mode;
		logic autoneg_en;
		logic speed_100;
		logic full_duplex;
		logic isolate;
		logic [2:0] phy_addr;
		logic cfg_done;
	} pscfg_cfg_s;

endpackage : pscfg_pkg
`default_nettype wire

// ---- verilog/pscfg_top.sv ----
// How it works
// - mac mode straps: 000 gives MII, a=1 b=0 c=1 gives RMII slave
// - autoneg strap 1 enables auto-negotiation, 0 disables it
// - speed strap 0 forces 10 Mb/s, 1 forces 100 Mb/s
// - duplex strap 0 gives full duplex, 1 gives half duplex
// - isolate strap 1 isolates the mac interface, 0 leaves it active
// - registers exist at each listed offset, base 0..1f and extended to 178
// - three address straps give the management address, default 001
// - strap read low is mode 0, read high is mode 1
`timescale 1ns/1ps
`default_nettype none
module pscfg_top
	import pscfg_pkg::*;
#(
	parameter logic [15:0] ID_HIGH = 16'h0a5a, // arbitrary value
	parameter logic [15:0] ID_LOW = 16'h5a50 // arbitrary value
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic mac_mode_select_a,
	input wire logic mac_mode_select_b,
	input wire logic mac_mode_select_c,
	input wire logic autoneg_select_pin,
	input wire logic speed_select_pin,
	input wire logic duplex_select_pin,
	input wire logic isolate_select_pin,
	input wire logic address_bit0_select,
	input wire logic address_bit1_select,
	input wire logic address_bit2_select,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output pscfg_cfg_s cfg
);

	// ------------------------------------------------------------
	// strap synchroniser
	// ------------------------------------------------------------
	logic [PSCFG_NSTRAP-1:0] strap_pins;
	logic [PSCFG_NSTRAP-1:0] strap_s1;
	logic [PSCFG_NSTRAP-1:0] strap_s2;

	assign strap_pins = {address_bit2_select, address_bit1_select,
		address_bit0_select, isolate_select_pin, duplex_select_pin,
		speed_select_pin, autoneg_select_pin, mac_mode_select_c,
		mac_mode_select_b, mac_mode_select_a};

	always_ff @(posedge clk) begin
		strap_s1 <= strap_pins;
		strap_s2 <= strap_s1;
	end

	// ------------------------------------------------------------
	// latch sequencer
	// ------------------------------------------------------------
	pscfg_st_e st;
	pscfg_st_e next_st;
	logic [1:0] cnt;

	always_comb begin
		next_st = st;
		case (st)
			PSCFG_ST_WAIT: begin
				if (cnt == 2'h0) begin
					next_st = PSCFG_ST_LATCH;
				end
			end
			PSCFG_ST_LATCH: begin
				next_st = PSCFG_ST_RUN;
			end
			PSCFG_ST_RUN: begin
				next_st = PSCFG_ST_RUN;
			end
			default: begin
				next_st = PSCFG_ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= PSCFG_ST_WAIT;
		end else begin
			st <= next_st;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= PSCFG_SETTLE_CYC;
		end else if (st == PSCFG_ST_WAIT && cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
		end
	end

	// ------------------------------------------------------------
	// strap decode and latch
	// ------------------------------------------------------------
	logic latch_now;
	logic [2:0] mode_bits;
	pscfg_mac_e next_mac;
	pscfg_mac_e mac_mode;
	logic [2:0] phy_addr;
	logic [15:0] strap_basic;

	assign latch_now = (st == PSCFG_ST_LATCH);
	assign mode_bits = {strap_s2[PSCFG_SB_MA], strap_s2[PSCFG_SB_MB],
		strap_s2[PSCFG_SB_MC]};

	always_comb begin
		case (mode_bits)
			PSCFG_MODE_MII: next_mac = PSCFG_MAC_MII;
			PSCFG_MODE_RMII_SLV: next_mac = PSCFG_MAC_RMII_SLV;
			default: next_mac = PSCFG_MAC_RSV;
		endcase
	end

	always_comb begin
		strap_basic = 16'h0000;
		strap_basic[PSCFG_BASIC_AN] = strap_s2[PSCFG_SB_AN];
		strap_basic[PSCFG_BASIC_SPD] = strap_s2[PSCFG_SB_SPD];
		strap_basic[PSCFG_BASIC_DUP] = ~strap_s2[PSCFG_SB_DUP];
		strap_basic[PSCFG_BASIC_ISO] = strap_s2[PSCFG_SB_ISO];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mac_mode <= PSCFG_MAC_MII;
		end else if (latch_now) begin
			mac_mode <= next_mac;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			phy_addr <= PSCFG_ADDR_DEF;
		end else if (latch_now) begin
			phy_addr <= strap_s2[PSCFG_SB_AD0+:3];
		end
	end

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	logic [PSCFG_NREG-1:0] dir_hit;
	logic [PSCFG_NREG-1:0] ext_hit;
	logic [15:0] ext_addr;
	logic [5:0] dir_idx;
	logic [5:0] ext_idx;
	logic dir_any;
	logic ext_any;

	function automatic logic [5:0] pscfg_enc(input logic [PSCFG_NREG-1:0] h);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 0; i < PSCFG_NREG; i++) begin
			if (h[i]) begin
				r = 6'(i);
			end
		end
		return r;
	endfunction : pscfg_enc

	function automatic logic pscfg_wable(input logic [5:0] idx);
		return idx != PSCFG_IDX_IDH && idx != PSCFG_IDX_IDL &&
			idx != PSCFG_IDX_STS && idx != PSCFG_IDX_DATA;
	endfunction : pscfg_wable

	for (genvar g = 0; g < PSCFG_NREG; g++) begin : g_hit
		assign dir_hit[g] = (PSCFG_OFFS[g] == {4'h0, reg_addr});
		assign ext_hit[g] = (ext_addr[15:9] == 7'h00) &&
			(PSCFG_OFFS[g] == ext_addr[8:0]);
	end

	assign dir_any = |dir_hit;
	assign ext_any = |ext_hit;
	assign dir_idx = pscfg_enc(dir_hit);
	assign ext_idx = pscfg_enc(ext_hit);

	// ------------------------------------------------------------
	// register storage and write path
	// ------------------------------------------------------------
	logic [15:0] mem [PSCFG_NREG];
	logic [1:0] ext_fn;
	logic data_wr;
	logic data_rd;
	logic wr_en;
	logic [5:0] wr_idx;

	assign ext_fn = mem[PSCFG_IDX_CTRL][PSCFG_CTRL_FN_HI:PSCFG_CTRL_FN_LO];
	assign data_wr = reg_wr && dir_any && dir_idx == PSCFG_IDX_DATA;
	assign data_rd = reg_rd && dir_any && dir_idx == PSCFG_IDX_DATA;

	always_comb begin
		wr_en = 1'b0;
		wr_idx = 6'h00;
		if (data_wr) begin
			if (ext_fn != PSCFG_FN_ADDR && ext_any && pscfg_wable(ext_idx) &&
				ext_idx != PSCFG_IDX_CTRL) begin
				wr_en = 1'b1;
				wr_idx = ext_idx;
			end
		end else if (reg_wr && dir_any && pscfg_wable(dir_idx)) begin
			wr_en = 1'b1;
			wr_idx = dir_idx;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < PSCFG_NREG; i++) begin
				mem[i] <= 16'h0000;
			end
			mem[PSCFG_IDX_BASIC] <= PSCFG_BASIC_DEF;
		end else begin
			if (wr_en) begin
				mem[wr_idx] <= reg_wdata;
			end
			// strap latch overrides a same-cycle control write only
			if (latch_now) begin
				mem[PSCFG_IDX_BASIC] <= strap_basic;
			end
		end
	end

	// ------------------------------------------------------------
	// extended address pointer
	// ------------------------------------------------------------
	logic ext_inc;

	assign ext_inc = (data_wr && (ext_fn == PSCFG_FN_INC_RW ||
		ext_fn == PSCFG_FN_INC_W)) || (data_rd && ext_fn == PSCFG_FN_INC_RW);

	always_ff @(posedge clk) begin
		if (rst) begin
			ext_addr <= 16'h0000;
		end else if (data_wr && ext_fn == PSCFG_FN_ADDR) begin
			ext_addr <= reg_wdata;
		end else if (ext_inc) begin
			ext_addr <= ext_addr + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic [15:0] sts_word;
	logic [15:0] ext_word;

	function automatic logic [15:0] pscfg_view(input logic [5:0] idx,
		input logic [15:0] raw, input logic [15:0] sts, input logic [2:0] pa);
		logic [15:0] v;
		v = raw;
		case (idx)
			PSCFG_IDX_IDH: v = ID_HIGH;
			PSCFG_IDX_IDL: v = ID_LOW;
			PSCFG_IDX_STS: v = sts;
			PSCFG_IDX_XCVR: v = {raw[15:3], pa};
			default: v = raw;
		endcase
		return v;
	endfunction : pscfg_view

	assign sts_word = {9'h000, latch_now || st == PSCFG_ST_RUN,
		mac_mode == PSCFG_MAC_RSV, mac_mode == PSCFG_MAC_RMII_SLV,
		cfg.isolate, cfg.autoneg_en, cfg.full_duplex, cfg.speed_100};
	assign ext_word = ext_any ?
		pscfg_view(ext_idx, mem[ext_idx], sts_word, phy_addr) : 16'h0000;

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (!reg_rd || !dir_any) begin
			reg_rdata <= 16'h0000;
		end else if (dir_idx == PSCFG_IDX_DATA) begin
			reg_rdata <= (ext_fn == PSCFG_FN_ADDR) ? ext_addr : ext_word;
		end else begin
			reg_rdata <= pscfg_view(dir_idx, mem[dir_idx], sts_word, phy_addr);
		end
	end

	// ------------------------------------------------------------
	// configuration outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg.mac_mode <= PSCFG_MAC_MII;
			cfg.autoneg_en <= PSCFG_BASIC_DEF[PSCFG_BASIC_AN];
			cfg.speed_100 <= PSCFG_BASIC_DEF[PSCFG_BASIC_SPD];
			cfg.full_duplex <= PSCFG_BASIC_DEF[PSCFG_BASIC_DUP];
			cfg.isolate <= PSCFG_BASIC_DEF[PSCFG_BASIC_ISO];
			cfg.phy_addr <= PSCFG_ADDR_DEF;
			cfg.cfg_done <= 1'b0;
		end else begin
			cfg.mac_mode <= mac_mode;
			cfg.autoneg_en <= mem[PSCFG_IDX_BASIC][PSCFG_BASIC_AN];
			cfg.speed_100 <= mem[PSCFG_IDX_BASIC][PSCFG_BASIC_SPD];
			cfg.full_duplex <= mem[PSCFG_IDX_BASIC][PSCFG_BASIC_DUP];
			cfg.isolate <= mem[PSCFG_IDX_BASIC][PSCFG_BASIC_ISO];
			cfg.phy_addr <= phy_addr;
			cfg.cfg_done <= (st == PSCFG_ST_RUN);
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence seq_latch_mii;
		latch_now && mode_bits == PSCFG_MODE_MII;
	endsequence

	sequence seq_latch_rmii;
		latch_now && mode_bits == PSCFG_MODE_RMII_SLV;
	endsequence

	sequence seq_settle_done;
		st == PSCFG_ST_WAIT && cnt == 2'h0;
	endsequence

	sequence seq_latch_then_run;
		st == PSCFG_ST_LATCH ##1 st == PSCFG_ST_RUN;
	endsequence

	AST_MII_SELECT: assert property (@(posedge clk) disable iff (rst)
		seq_latch_mii |-> ##2 cfg.mac_mode == PSCFG_MAC_MII)
		else $error("mii strap not applied");

	AST_RMII_SELECT: assert property (@(posedge clk) disable iff (rst)
		seq_latch_rmii |-> ##2 cfg.mac_mode == PSCFG_MAC_RMII_SLV)
		else $error("rmii slave strap not applied");

	AST_AUTONEG: assert property (@(posedge clk) disable iff (rst)
		latch_now |-> ##2 cfg.autoneg_en == $past(strap_s2[PSCFG_SB_AN], 2))
		else $error("autoneg strap not applied");

	AST_SPEED: assert property (@(posedge clk) disable iff (rst)
		latch_now |-> ##2 cfg.speed_100 == $past(strap_s2[PSCFG_SB_SPD], 2))
		else $error("speed strap not applied");

	AST_DUPLEX: assert property (@(posedge clk) disable iff (rst)
		latch_now |-> ##2 cfg.full_duplex != $past(strap_s2[PSCFG_SB_DUP], 2))
		else $error("duplex strap not applied");

	AST_ISOLATE: assert property (@(posedge clk) disable iff (rst)
		latch_now |-> ##2 cfg.isolate == $past(strap_s2[PSCFG_SB_ISO], 2))
		else $error("isolate strap not applied");

	AST_ADDRESS: assert property (@(posedge clk) disable iff (rst)
		latch_now |-> ##2 cfg.phy_addr == $past(strap_s2[PSCFG_SB_AD0+:3], 2))
		else $error("address straps not applied");

	AST_LATCH_SEQ: assert property (@(posedge clk) disable iff (rst)
		seq_settle_done |=> seq_latch_then_run)
		else $error("strap latch sequence broken");

	AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (rst)
		st == PSCFG_ST_RUN |=> st == PSCFG_ST_RUN && $stable(phy_addr) &&
		$stable(mac_mode))
		else $error("latched straps changed after start");

	AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (rst)
		reg_rd && !dir_any |=> reg_rdata == 16'h0000)
		else $error("unmapped offset read nonzero");

	AST_BASIC_WRITE: assert property (@(posedge clk) disable iff (rst)
		st == PSCFG_ST_RUN && reg_wr && reg_addr == PSCFG_OFF_BASIC[4:0] |->
		##2 cfg.speed_100 == $past(reg_wdata[PSCFG_BASIC_SPD], 2))
		else $error("control write did not steer speed");

	AST_EXT_INDIRECT: assert property (@(posedge clk) disable iff (rst)
		wr_en && wr_idx >= 6'(PSCFG_NBASE) |->
		reg_wr && reg_addr == PSCFG_OFF_DATA[4:0])
		else $error("extended register written directly");

endmodule : pscfg_top
`default_nettype wire
